// ===== pkg/cbs_cfg.svh
// register map, field positions, reset values and timing figures of the balancing sequencer
// assumes inclusion by the sequencer, the property module and the bench
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH

`define CBS_OFF_CONFIG 8'h00
`define CBS_OFF_THRESH 8'h04
`define CBS_OFF_DEGLITCH 8'h08
`define CBS_OFF_CONTROL 8'h0c
`define CBS_OFF_STATUS 8'h10
`define CBS_OFF_FINISHED 8'h14
`define CBS_OFF_SWITCH 8'h18
`define CBS_OFF_TIMER0 8'h20
`define CBS_OFF_TIMER5 8'h34

`define CBS_CFG_ORDER_LSB 0
`define CBS_CFG_DUTY_LSB 2
`define CBS_CFG_DUTY_UNIT 5
`define CBS_CFG_HALT 6
`define CBS_THR_ENABLE 0
`define CBS_THR_VALUE_LSB 1
`define CBS_CTL_LAUNCH 0
`define CBS_CTL_HOLD 1
`define CBS_STA_RUNNING 0
`define CBS_STA_HOLD 1
`define CBS_STA_DONE 2
`define CBS_FIN_ABORT 6
`define CBS_TMR_UNIT 7

`define CBS_RST_CONFIG 8'h00
`define CBS_RST_THRESH 8'h00
`define CBS_RST_DEGLITCH 8'h01
`define CBS_RST_TIMER 8'h00

`define CBS_ODD_BANK 6'h15
`define CBS_EVEN_BANK 6'h2a
`define CBS_RESP_OKAY 2'b00
`define CBS_RESP_SLVERR 2'b10

`define CBS_CLK_HZ 50000000
`define CBS_SLOT_US 1000
`define CBS_SEC_PER_MIN 60

`endif

// ===== pkg/cbs_pkg.sv
// types shared by the balancing sequencer modules
// assumes the constants header sits beside it
package cbs_pkg;
  typedef enum {cbs_idle, cbs_run, cbs_fin} cbs_state_t;
  typedef enum logic [1:0] {
    cbs_odd_only = 2'h0,
    cbs_even_only = 2'h1,
    cbs_odd_even = 2'h2,
    cbs_even_odd = 2'h3
  } cbs_order_t;
endpackage

// ===== src/cbs_timer.sv
// loadable down counter in whole time units
// assumes the caller supplies one run pulse per elapsed unit
`timescale 1ns/100ps
module cbs_timer import cbs_pkg::*; #(
  parameter int W = 7
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic run,
  output logic expired
);
  logic [W-1:0] cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= load_val;
    end else if (run && cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign expired = (cnt == '0);
endmodule

// ===== src/cbs_deglitch.sv
// up/down deglitch counter for one cell's finish comparator result
// assumes one sample pulse per visit of the round-robin comparator
`timescale 1ns/100ps
module cbs_deglitch import cbs_pkg::*; #(
  parameter int W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic sample,
  input wire logic tripped,
  input wire logic [W-1:0] limit,
  output logic hit
);
  logic [W-1:0] cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt <= '0;
    end else if (sample) begin
      if (tripped && cnt < limit) begin
        cnt <= cnt + 1'b1;
      end else if (!tripped && cnt != '0) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  assign hit = sample && tripped && ({1'b0, cnt} + 1'b1 >= {1'b0, limit});
endmodule

// ===== src/cbs_sequencer.sv
// autonomous six-cell passive balancing sequencer with an axi4-lite register slave
// assumes synchronous inputs, an unmasked fault level and a finish comparator on the selected cell
`timescale 1ns/100ps
`include "cbs_cfg.svh"

module cbs_sequencer import cbs_pkg::*; #(
  parameter int SEC_CYCLES = `CBS_CLK_HZ,
  parameter int SLOT_CYCLES = `CBS_SLOT_US * (`CBS_CLK_HZ / 1000000)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic unmasked_fault,
  input wire logic finish_comparator,
  output logic [5:0] switch_en,
  output logic [2:0] comp_cell_sel,
  output logic comp_enable,
  output logic [6:0] finish_voltage_threshold,
  output logic window_monitor_pause
);
  if (SEC_CYCLES < 2 || SLOT_CYCLES < 1) begin : g_bad_param
    $error("cbs_sequencer: timing parameters too small");
  end

  function automatic logic is_timer(input logic [7:0] a);
    return a >= `CBS_OFF_TIMER0 && a <= `CBS_OFF_TIMER5 && a[1:0] == 2'h0;
  endfunction

  function automatic logic [5:0] bank_mask(input logic even);
    return even ? `CBS_EVEN_BANK : `CBS_ODD_BANK;
  endfunction

  function automatic logic [2:0] next_cell(input logic [2:0] cur, input logic [5:0] on);
    logic [2:0] n;
    logic [2:0] res;
    n = cur;
    res = cur;
    for (int k = 0; k < 6; k++) begin
      n = (n == 3'h5) ? 3'h0 : n + 3'h1;
      if (on[n] && res == cur) begin
        res = n;
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_go;
  logic wr_en;
  logic wr_map;
  logic [31:0] rd_mux;
  logic rd_map;

  assign wr_go = aw_held && w_held && !bvalid;
  assign wr_en = wr_go && wr_strb[0];
  assign wr_map = wr_addr == `CBS_OFF_CONFIG || wr_addr == `CBS_OFF_THRESH || wr_addr == `CBS_OFF_DEGLITCH ||
    wr_addr == `CBS_OFF_CONTROL || wr_addr == `CBS_OFF_STATUS || wr_addr == `CBS_OFF_FINISHED ||
    wr_addr == `CBS_OFF_SWITCH || is_timer(wr_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      aw_held <= 1'b0;
      wr_addr <= 8'h00;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_held <= 1'b1;
      wr_addr <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
      aw_held <= 1'b0;
    end else if (!aw_held) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_held <= 1'b0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_held <= 1'b1;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
      w_held <= 1'b0;
    end else if (!w_held) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `CBS_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_map ? `CBS_RESP_OKAY : `CBS_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `CBS_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_map ? rd_mux : 32'h0;
      rresp <= rd_map ? `CBS_RESP_OKAY : `CBS_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [7:0] config_reg;
  logic [7:0] thresh_reg;
  logic [3:0] deglitch_reg;
  logic hold;
  logic [7:0] timer_reg [6];
  logic launch;
  cbs_state_t state;
  logic [5:0] flags;
  logic abort;

  assign launch = wr_en && wr_addr == `CBS_OFF_CONTROL && wr_data[`CBS_CTL_LAUNCH];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg <= `CBS_RST_CONFIG;
      deglitch_reg <= 4'(`CBS_RST_DEGLITCH);
      hold <= 1'b0;
    end else if (wr_en) begin
      if (wr_addr == `CBS_OFF_CONFIG) begin
        config_reg <= wr_data[7:0];
      end
      if (wr_addr == `CBS_OFF_DEGLITCH) begin
        deglitch_reg <= wr_data[3:0];
      end
      if (wr_addr == `CBS_OFF_CONTROL) begin
        hold <= wr_data[`CBS_CTL_HOLD];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thresh_reg <= `CBS_RST_THRESH;
    end else if (wr_en && wr_addr == `CBS_OFF_THRESH && state != cbs_run) begin
      thresh_reg <= wr_data[7:0];
    end
  end

  for (genvar g = 0; g < 6; g++) begin : g_treg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        timer_reg[g] <= `CBS_RST_TIMER;
      end else if (wr_en && wr_addr == `CBS_OFF_TIMER0 + 8'(4 * g)) begin
        timer_reg[g] <= wr_data[7:0];
      end
    end
  end

  always_comb begin
    rd_map = 1'b1;
    rd_mux = 32'h0;
    case (araddr)
      `CBS_OFF_CONFIG: rd_mux = {24'h0, config_reg};
      `CBS_OFF_THRESH: rd_mux = {24'h0, thresh_reg};
      `CBS_OFF_DEGLITCH: rd_mux = {28'h0, deglitch_reg};
      `CBS_OFF_CONTROL: rd_mux = {30'h0, hold, 1'b0};
      `CBS_OFF_STATUS: rd_mux = {29'h0, state == cbs_fin, state == cbs_run && hold, state == cbs_run};
      `CBS_OFF_FINISHED: rd_mux = {25'h0, abort, flags};
      `CBS_OFF_SWITCH: rd_mux = {26'h0, switch_en};
      default: begin
        if (is_timer(araddr)) begin
          rd_mux = {24'h0, timer_reg[3'(araddr[4:2])]};
        end else begin
          rd_map = 1'b0;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // launch capture
  cbs_order_t c_order;
  logic [2:0] c_duty;
  logic c_duty_unit;
  logic c_cell_unit;
  logic c_halt;
  logic c_comp_en;
  logic [3:0] c_dg;
  logic [5:0] sched;
  logic [5:0] next_sched;
  logic [5:0] zero_mask;

  always_comb begin
    case (cbs_order_t'(config_reg[`CBS_CFG_ORDER_LSB +: 2]))
      cbs_odd_only: next_sched = `CBS_ODD_BANK;
      cbs_even_only: next_sched = `CBS_EVEN_BANK;
      default: next_sched = 6'h3f;
    endcase
    for (int k = 0; k < 6; k++) begin
      zero_mask[k] = timer_reg[k][6:0] == 7'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_order <= cbs_odd_only;
      c_duty <= 3'h0;
      c_duty_unit <= 1'b0;
      c_cell_unit <= 1'b0;
      c_halt <= 1'b0;
      c_comp_en <= 1'b0;
      c_dg <= 4'h0;
      sched <= 6'h00;
      finish_voltage_threshold <= 7'h00;
    end else if (launch) begin
      c_order <= cbs_order_t'(config_reg[`CBS_CFG_ORDER_LSB +: 2]);
      c_duty <= config_reg[`CBS_CFG_DUTY_LSB +: 3];
      c_duty_unit <= config_reg[`CBS_CFG_DUTY_UNIT];
      c_cell_unit <= timer_reg[0][`CBS_TMR_UNIT];
      c_halt <= config_reg[`CBS_CFG_HALT];
      c_comp_en <= thresh_reg[`CBS_THR_ENABLE];
      c_dg <= deglitch_reg;
      sched <= next_sched & ~zero_mask;
      finish_voltage_threshold <= thresh_reg[`CBS_THR_VALUE_LSB +: 7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // time base and timers
  logic [$clog2(SEC_CYCLES)-1:0] sec_cnt;
  logic [5:0] min_cnt;
  logic sec_tick;
  logic min_tick;
  logic duty_on;
  logic duty_exp;
  logic duty_load;
  logic active;
  logic [5:0] tmr_exp;
  logic [5:0] dg_hit;
  logic [5:0] dg_sample;

  assign active = state == cbs_run && !hold;
  assign duty_on = c_duty != 3'h0 && (c_order == cbs_odd_even || c_order == cbs_even_odd);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_cnt <= '0;
      min_cnt <= 6'h00;
      sec_tick <= 1'b0;
      min_tick <= 1'b0;
    end else begin
      sec_tick <= sec_cnt == $bits(sec_cnt)'(SEC_CYCLES - 1);
      min_tick <= sec_cnt == $bits(sec_cnt)'(SEC_CYCLES - 1) && min_cnt == 6'(`CBS_SEC_PER_MIN - 1);
      if (sec_cnt == $bits(sec_cnt)'(SEC_CYCLES - 1)) begin
        sec_cnt <= '0;
        min_cnt <= (min_cnt == 6'(`CBS_SEC_PER_MIN - 1)) ? 6'h00 : min_cnt + 6'h01;
      end else begin
        sec_cnt <= sec_cnt + 1'b1;
      end
    end
  end

  for (genvar g = 0; g < 6; g++) begin : g_cell
    cbs_timer #(.W(7)) u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .load(launch),
      .load_val(timer_reg[g][6:0]),
      .run(switch_en[g] && (c_cell_unit ? min_tick : sec_tick)),
      .expired(tmr_exp[g])
    );
    cbs_deglitch #(.W(4)) u_dg (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(launch),
      .sample(dg_sample[g]),
      .tripped(finish_comparator),
      .limit(c_dg),
      .hit(dg_hit[g])
    );
  end

  cbs_timer #(.W(3)) u_duty (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(duty_load),
    .load_val(launch ? config_reg[`CBS_CFG_DUTY_LSB +: 3] : c_duty),
    .run(active && (c_duty_unit ? min_tick : sec_tick)),
    .expired(duty_exp)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // round-robin finish comparator
  logic [$clog2(SLOT_CYCLES + 1)-1:0] slot_cnt;
  logic slot_end;

  assign slot_end = slot_cnt == $bits(slot_cnt)'(SLOT_CYCLES - 1);
  assign dg_sample = (comp_enable && slot_end) ? (switch_en & (6'h01 << comp_cell_sel)) : 6'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_cnt <= '0;
      comp_cell_sel <= 3'h0;
      comp_enable <= 1'b0;
      window_monitor_pause <= 1'b0;
    end else begin
      comp_enable <= active && c_comp_en && switch_en != 6'h00;
      window_monitor_pause <= state == cbs_run && c_comp_en;
      if (!comp_enable || slot_end) begin
        slot_cnt <= '0;
      end else begin
        slot_cnt <= slot_cnt + 1'b1;
      end
      if (!comp_enable || slot_end) begin
        comp_cell_sel <= next_cell(comp_cell_sel, switch_en);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer
  logic bank;
  logic [5:0] cell_end;
  logic [5:0] next_flags;
  logic fin_cur;
  logic fin_other;
  logic halt_now;

  assign cell_end = switch_en & (tmr_exp | dg_hit);
  assign next_flags = flags | cell_end;
  assign fin_cur = (bank_mask(bank) & sched & ~next_flags) == 6'h00;
  assign fin_other = (bank_mask(~bank) & sched & ~next_flags) == 6'h00;
  assign halt_now = unmasked_fault && c_halt;
  assign duty_load = launch || (active && !halt_now && !fin_cur && duty_on && duty_exp && !fin_other);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= cbs_idle;
      flags <= 6'h00;
      abort <= 1'b0;
      bank <= 1'b0;
    end else if (launch) begin
      state <= cbs_run;
      flags <= next_sched & zero_mask;
      abort <= 1'b0;
      bank <= config_reg[`CBS_CFG_ORDER_LSB];
    end else if (wr_en && wr_addr == `CBS_OFF_FINISHED && state != cbs_run) begin
      flags <= wr_data[5:0];
      abort <= wr_data[`CBS_FIN_ABORT];
    end else if (active) begin
      if (halt_now) begin
        state <= cbs_fin;
        abort <= 1'b1;
      end else begin
        flags <= next_flags;
        if (fin_cur && fin_other) begin
          state <= cbs_fin;
        end else if (fin_cur) begin
          bank <= ~bank;
        end else if (duty_on && duty_exp && !fin_other) begin
          bank <= ~bank;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      switch_en <= 6'h00;
    end else if (active && !halt_now) begin
      switch_en <= bank_mask(bank) & sched & ~next_flags;
    end else begin
      switch_en <= 6'h00;
    end
  end
endmodule

// ===== bench/cbs_sequencer_props.sv
// concurrent checks on the balancing sequencer ports
// assumes a bind to cbs_sequencer and a single clock domain
`timescale 1ns/100ps
`include "cbs_cfg.svh"
module cbs_sequencer_props #(
  parameter int SEC_CYCLES = 60,
  parameter int SLOT_CYCLES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [5:0] switch_en,
  input wire logic [2:0] comp_cell_sel,
  input wire logic comp_enable,
  input wire logic [6:0] finish_voltage_threshold,
  input wire logic window_monitor_pause
);
  logic [7:0] rd_addr;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // address of the read under way
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_addr <= 8'h00;
    end else if (arvalid && arready) begin
      rd_addr <= araddr;
    end
  end
  ////////////////////////////////////////////////////////////////
  reset_quiet_a: assert property ($rose(aresetn) |-> switch_en == 6'h00 && !comp_enable)
    else $error("switches or comparator active after reset");
  one_bank_a: assert property (!(|(switch_en & `CBS_ODD_BANK) && |(switch_en & `CBS_EVEN_BANK)))
    else $error("odd and even switches closed together");
  sel_range_a: assert property (comp_enable |-> comp_cell_sel <= 3'h5)
    else $error("comparator selects no cell");
  mon_pause_a: assert property (comp_enable |-> window_monitor_pause)
    else $error("window monitor not paused");
  thresh_frozen_a: assert property (window_monitor_pause && $past(window_monitor_pause)
    |-> $stable(finish_voltage_threshold))
    else $error("threshold changed during run");
  switch_mirror_a: assert property ($rose(rvalid) && rd_addr == `CBS_OFF_SWITCH |-> rdata[5:0] == $past(switch_en))
    else $error("switch state read differs");
  write_stands_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  read_stands_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule
bind cbs_sequencer cbs_sequencer_props #(.SEC_CYCLES(SEC_CYCLES), .SLOT_CYCLES(SLOT_CYCLES)) u_cbs_sequencer_props (
  .aclk(aclk), .aresetn(aresetn), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rvalid(rvalid), .rready(rready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .switch_en(switch_en), .comp_cell_sel(comp_cell_sel), .comp_enable(comp_enable),
  .finish_voltage_threshold(finish_voltage_threshold), .window_monitor_pause(window_monitor_pause)
);

// ===== bench/tb_cbs_sequencer.sv
// self-checking bench for the balancing sequencer
// assumes short prescaler counts: 4 cycles a second, 240 cycles a minute, 4 cycles a slot
`timescale 1ns/100ps
`include "cbs_cfg.svh"
module tb_cbs_sequencer;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, unmasked_fault = 1'b0, finish_comparator = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, comp_enable, window_monitor_pause;
  logic [5:0] switch_en, trip = 6'h00;
  logic [2:0] comp_cell_sel;
  logic [6:0] finish_voltage_threshold;
  int fails = 0, n_compared = 0;
  localparam logic [31:0] ok = 32'h0, err = 32'h2;
  cbs_sequencer #(.SEC_CYCLES(4), .SLOT_CYCLES(4)) u_cbs_sequencer (.*);
  always #10 aclk = ~aclk;
  // cell voltage below threshold for the cells marked in trip
  always @(posedge aclk) finish_comparator <= comp_enable && trip[comp_cell_sel];
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 400) begin
      fails++;
      $display("wrong value at %0t: wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 400);
    hang(n);
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    chk(32'(bresp), er);
  endtask
  task automatic rdq(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 400);
    hang(n);
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    rv = rdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] er);
    rdq(a);
    chk(32'(rresp), er);
    chk(rv, exp);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rdq(`CBS_OFF_STATUS);
      n++;
    end while (rv[2] !== 1'b1 && n < 400);
    hang(n);
  endtask
  task automatic wait_sw(input logic [5:0] e);
    int n;
    n = 0;
    while (switch_en !== e && n < 400) begin
      @(posedge aclk);
      n++;
    end
    hang(n);
  endtask
  task automatic set_t(input logic [6:0] t [6]);
    for (int i = 0; i < 6; i++) begin
      wr(8'(`CBS_OFF_TIMER0 + 4 * i), 32'(t[i]), ok);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CBS_OFF_DEGLITCH, 32'h1, ok);
    rd(`CBS_OFF_STATUS, 32'h0, ok);
    wr(8'h1c, 32'h1, err);
    rd(8'h1c, 32'h0, err);
    wstrb <= 4'h0;
    wr(`CBS_OFF_DEGLITCH, 32'h5, ok);
    wstrb <= 4'hf;
    rd(`CBS_OFF_DEGLITCH, 32'h1, ok);
    // odd bank only, flags preset while idle
    wr(`CBS_OFF_FINISHED, 32'h3f, ok);
    set_t('{7'd8, 7'd5, 7'd0, 7'd0, 7'd10, 7'd0});
    wr(`CBS_OFF_CONTROL, 32'h1, ok);
    rd(`CBS_OFF_FINISHED, 32'h04, ok);
    chk(32'(switch_en), 32'h11);
    wr(`CBS_OFF_THRESH, 32'h0b, ok);
    wr(`CBS_OFF_FINISHED, 32'h3f, ok);
    wr(`CBS_OFF_CONFIG, 32'h01, ok);
    chk(32'(switch_en), 32'h11);
    wait_done();
    rd(`CBS_OFF_FINISHED, 32'h15, ok);
    rd(`CBS_OFF_STATUS, 32'h04, ok);
    rd(`CBS_OFF_THRESH, 32'h0, ok);
    // even then odd, comparator on, fault halt
    set_t('{7'd20, 7'd20, 7'd20, 7'd20, 7'd20, 7'd20});
    wr(`CBS_OFF_CONFIG, 32'h43, ok);
    wr(`CBS_OFF_THRESH, 32'h0b, ok);
    wr(`CBS_OFF_DEGLITCH, 32'h2, ok);
    trip <= 6'h02;
    wr(`CBS_OFF_CONTROL, 32'h1, ok);
    wait_sw(6'h2a);
    chk(32'(window_monitor_pause), 32'h1);
    chk(32'(finish_voltage_threshold), 32'h5);
    wait_sw(6'h28);
    rd(`CBS_OFF_FINISHED, 32'h02, ok);
    trip <= 6'h00;
    repeat (20) @(posedge aclk);
    chk(32'(switch_en), 32'h28);
    wait_sw(6'h15);
    wr(`CBS_OFF_CONTROL, 32'h2, ok);
    wait_sw(6'h00);
    rd(`CBS_OFF_STATUS, 32'h03, ok);
    unmasked_fault <= 1'b1;
    rd(`CBS_OFF_FINISHED, 32'h2a, ok);
    wr(`CBS_OFF_CONTROL, 32'h0, ok);
    rd(`CBS_OFF_FINISHED, 32'h6a, ok);
    chk(32'(switch_en), 32'h0);
    rd(`CBS_OFF_STATUS, 32'h04, ok);
    unmasked_fault <= 1'b0;
    // duty cycling, both units in seconds
    wr(`CBS_OFF_THRESH, 32'h0, ok);
    wr(`CBS_OFF_CONFIG, 32'h06, ok);
    set_t('{7'd12, 7'd1, 7'd12, 7'd1, 7'd12, 7'd1});
    wr(`CBS_OFF_CONTROL, 32'h1, ok);
    wait_sw(6'h15);
    wait_sw(6'h2a);
    wait_sw(6'h15);
    for (int i = 0; i < 30; i++) begin
      @(posedge aclk);
      chk(32'(switch_en & 6'h2a), 32'h0);
    end
    wait_done();
    rd(`CBS_OFF_FINISHED, 32'h3f, ok);
    // early stop by relaunch in mid-run with zero timers
    set_t('{7'd20, 7'd20, 7'd20, 7'd20, 7'd20, 7'd20});
    wr(`CBS_OFF_CONFIG, 32'h02, ok);
    wr(`CBS_OFF_CONTROL, 32'h1, ok);
    wait_sw(6'h15);
    set_t('{7'd0, 7'd0, 7'd0, 7'd0, 7'd0, 7'd0});
    wr(`CBS_OFF_CONTROL, 32'h1, ok);
    wait_done();
    chk(32'(switch_en), 32'h0);
    rd(`CBS_OFF_FINISHED, 32'h3f, ok);
    // cell one alone, timer in minutes
    wr(`CBS_OFF_TIMER0, 32'h82, ok);
    wr(`CBS_OFF_CONTROL, 32'h1, ok);
    repeat (30) @(posedge aclk);
    chk(32'(switch_en), 32'h01);
    wait_done();
    rd(`CBS_OFF_FINISHED, 32'h3f, ok);
    set_t('{7'd20, 7'd20, 7'd20, 7'd20, 7'd20, 7'd20});
    wr(`CBS_OFF_CONTROL, 32'h1, ok);
    wait_sw(6'h15);
    rd(`CBS_OFF_SWITCH, 32'h15, ok);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(switch_en), 32'h0);
    rd(`CBS_OFF_STATUS, 32'h0, ok);
    rd(`CBS_OFF_TIMER0, 32'h0, ok);
    tally_and_finish();
  end
endmodule
